//--- verilog/cmc_mode_ctrl.sv
// Purpose: mode control, sleep/init handshakes and quantum clock of a
//          can controller, with APB register access
// Assumes: protocol engine on clk_sys drives tx_bit, sample_tick and
//          status; osc_en is a one-cycle pulse at the oscillator rate
// Notes: APB answers with no wait states, read data is registered
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cmc_mode_ctrl (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic can_rx,
  output logic can_tx,
  input wire logic special_mode,
  // protocol clock source
  input wire logic osc_en,
  // protocol engine status
  input wire logic tx_bit,
  input wire logic sample_tick,
  input wire logic rx_busy,
  input wire logic tx_empty,
  input wire logic bus_off,
  // protocol engine control
  output logic engine_run,
  output logic rx_bit,
  output logic abort,
  output logic bus_synced,
  output logic tq_tick,
  output logic [2:0] jump_width,
  output logic suppress_ack_err,
  output logic err_cnt_freeze,
  output logic tx_start_ok,
  output logic auto_recover,
  output logic recover_req
);
  import cmc_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic rx_meta_q, rx_sync_q, sm_meta_q, sm_sync_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
      sm_meta_q <= 1'b0;
      sm_sync_q <= 1'b0;
    end else begin
      rx_meta_q <= can_rx;
      rx_sync_q <= rx_meta_q;
      sm_meta_q <= special_mode;
      sm_sync_q <= sm_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic init_req_q, sleep_req_q, wake_en_q, sleep_ack_q;
  logic [7:2] ctl1_q;
  logic [7:0] btr0_q;
  logic enable_lock_q;
  cmc_mode_t mode_q;
  logic [3:0] idle_cnt_q;
  logic synced_q;
  logic recover_q;
  logic [31:0] rdata_q;
  logic wake;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  logic wr_acc, rd_setup, init_mode, sleep_mode, mapped;
  logic init_ack;
  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign init_ack = (mode_q == CMC_INIT);
  assign init_mode = init_req_q && init_ack;
  assign sleep_mode = sleep_req_q && sleep_ack_q;
  assign mapped = hit(paddr, CMC_OFS_CTL0) || hit(paddr, CMC_OFS_CTL1) ||
                  hit(paddr, CMC_OFS_BTR0) || hit(paddr, CMC_OFS_STAT);

  // ----------------------------------------------------------------
  // control zero: requests and wake enable
  // ----------------------------------------------------------------
  logic wr_c0;
  assign wr_c0 = wr_acc && hit(paddr, CMC_OFS_CTL0);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      init_req_q <= CMC_RST_INIT_REQ;
    end else if (wr_c0) begin
      // a request cannot be withdrawn before it is acknowledged
      if (pwdata[CMC_C0_INIT_REQ] || init_ack) begin
        init_req_q <= pwdata[CMC_C0_INIT_REQ];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wake_en_q <= 1'b0;
    end else if (wr_c0) begin
      wake_en_q <= pwdata[CMC_C0_WAKE_EN];
    end
  end

  // software set wins over a wake clearing in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sleep_req_q <= 1'b0;
    end else if (wr_c0 && pwdata[CMC_C0_SLEEP_REQ]) begin
      sleep_req_q <= 1'b1;
    end else if (wr_c0 && sleep_ack_q) begin
      sleep_req_q <= 1'b0;
    end else if (wake) begin
      sleep_req_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // sleep handshake
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sleep_ack_q <= 1'b0;
    end else if (!sleep_req_q) begin
      sleep_ack_q <= 1'b0;
    end else if (wr_c0 && sleep_ack_q && !pwdata[CMC_C0_SLEEP_REQ]) begin
      sleep_ack_q <= 1'b0;
    end else if (wake) begin
      sleep_ack_q <= 1'b0;
    end else if (!rx_busy && tx_empty) begin
      sleep_ack_q <= 1'b1;
    end
  end

  cmc_wake_filter u_wake (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .armed(sleep_mode && wake_en_q),
    .filtered(ctl1_q[CMC_C1_WAKE_FILT]),
    .rx_dom(!rx_sync_q),
    .wake(wake)
  );

  // ----------------------------------------------------------------
  // control one and bit timing zero
  // ----------------------------------------------------------------
  logic wr_c1, wr_b0, enable_ok;
  assign wr_c1 = wr_acc && hit(paddr, CMC_OFS_CTL1) && init_mode;
  assign wr_b0 = wr_acc && hit(paddr, CMC_OFS_BTR0) && init_mode;
  assign enable_ok = sm_sync_q || !enable_lock_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctl1_q[6:2] <= CMC_RST_CTL1[6:2];
    end else if (wr_c1) begin
      ctl1_q[6:2] <= pwdata[6:2];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctl1_q[CMC_C1_ENABLE] <= CMC_RST_CTL1[CMC_C1_ENABLE];
      enable_lock_q <= 1'b0;
    end else if (wr_c1 && enable_ok) begin
      ctl1_q[CMC_C1_ENABLE] <= pwdata[CMC_C1_ENABLE];
      enable_lock_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      btr0_q <= CMC_RST_BTR0;
    end else if (wr_b0) begin
      btr0_q <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // initialization and resynchronisation sequence
  // ----------------------------------------------------------------
  logic module_on;
  assign module_on = ctl1_q[CMC_C1_ENABLE];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= CMC_INIT;
    end else begin
      unique case (mode_q)
        CMC_RUN, CMC_SYNC: begin
          if (init_req_q) begin
            mode_q <= CMC_ABORT;
          end else if (mode_q == CMC_SYNC && synced_q) begin
            mode_q <= CMC_RUN;
          end
        end
        CMC_ABORT: begin
          mode_q <= CMC_INIT;
        end
        CMC_INIT: begin
          if (!init_req_q) begin
            mode_q <= CMC_SYNC;
          end
        end
      endcase
    end
  end

  // count recessive samples; a dominant one restarts the count
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt_q <= 4'h0;
      synced_q <= 1'b0;
    end else if (mode_q != CMC_SYNC && mode_q != CMC_RUN) begin
      idle_cnt_q <= 4'h0;
      synced_q <= 1'b0;
    end else if (mode_q == CMC_SYNC && sample_tick && module_on) begin
      if (!rx_bit) begin
        idle_cnt_q <= 4'h0;
      end else if (idle_cnt_q + 4'h1 >= CMC_IDLE_BITS && !bus_off) begin
        synced_q <= 1'b1;
      end else if (idle_cnt_q != CMC_IDLE_BITS) begin
        idle_cnt_q <= idle_cnt_q + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // bus-off recovery request
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      recover_q <= 1'b0;
    end else begin
      recover_q <= wr_c0 && pwdata[CMC_C0_RECOVER] && bus_off &&
                   ctl1_q[CMC_C1_BUSOFF_SEL];
    end
  end

  // ----------------------------------------------------------------
  // quantum clock
  // ----------------------------------------------------------------
  cmc_tq_if tq_link ();

  assign tq_link.run = module_on;
  assign tq_link.proto_en = ctl1_q[CMC_C1_CLK_SEL] ? 1'b1 : osc_en;
  assign tq_link.prescale = btr0_q[5:0];

  cmc_quantum_div u_div (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tq(tq_link)
  );

  // ----------------------------------------------------------------
  // apb read path
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit(paddr, CMC_OFS_CTL0)) begin
      rd_mux[CMC_C0_INIT_REQ] = init_req_q;
      rd_mux[CMC_C0_SLEEP_REQ] = sleep_req_q;
      rd_mux[CMC_C0_WAKE_EN] = wake_en_q;
    end else if (hit(paddr, CMC_OFS_CTL1)) begin
      rd_mux[7:2] = ctl1_q;
      rd_mux[CMC_C1_SLEEP_ACK] = sleep_ack_q;
      rd_mux[CMC_C1_INIT_ACK] = init_ack;
    end else if (hit(paddr, CMC_OFS_BTR0)) begin
      rd_mux[7:0] = btr0_q;
    end else if (hit(paddr, CMC_OFS_STAT)) begin
      rd_mux[CMC_ST_SYNCED] = synced_q;
      rd_mux[CMC_ST_BUS_OFF] = bus_off;
      rd_mux[CMC_ST_ENABLE_LOCK] = enable_lock_q;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_setup) begin
      rdata_q <= rd_mux;
    end
  end

  assign prdata = rdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ----------------------------------------------------------------
  // engine control and pins
  // ----------------------------------------------------------------
  logic listen, run_ok;
  assign listen = ctl1_q[CMC_C1_LISTEN];
  assign run_ok = module_on && mode_q == CMC_RUN && !sleep_mode;

  assign engine_run = run_ok;
  assign abort = (mode_q == CMC_ABORT);
  assign bus_synced = synced_q;
  assign tq_tick = tq_link.tq_tick;
  assign jump_width = {1'b0, btr0_q[7:6]} + 3'h1;
  assign suppress_ack_err = listen;
  assign err_cnt_freeze = listen;
  assign tx_start_ok = run_ok && !listen;
  assign auto_recover = !ctl1_q[CMC_C1_BUSOFF_SEL];
  assign recover_req = recover_q;
  assign rx_bit = ctl1_q[CMC_C1_LOOPBACK] ? tx_bit : rx_sync_q;

  // the pin goes recessive at once on an init request, in loopback,
  // listen-only and sleep, so no protocol violation can reach the bus
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      can_tx <= 1'b1;
    end else if (!run_ok || init_req_q || listen ||
                 ctl1_q[CMC_C1_LOOPBACK]) begin
      can_tx <= 1'b1;
    end else begin
      can_tx <= tx_bit;
    end
  end
endmodule
`default_nettype wire

//--- inc/cmc_pkg.sv
// Purpose: constants and types for the can mode control and bit timing block
// Assumes: 50 MHz system clock, APB register access with 32-bit words
// Notes: register offsets are byte addresses
//
// Summary of operation
// - enable bit low stops quantum clock, bus sync and engine run
// - enable writable once, or always in special
// - control one written only in init mode
// - clock select: oscillator or bus clock
// - loopback feeds transmit stream into receiver
// - listen-only receives but sends no ack/error
// - listen-only freezes both error counters
// - listen-only never starts a transmission
// - bus-off recovery automatic or on request
// - wake on any dominant or filtered pulse
// - sleep ack set on sleep entry
// - bus activity in sleep clears sleep ack
// - clearing sleep request clears sleep ack
// - init ack reports initialization mode entry
// - config registers writable only in init mode
// - bit timing zero read anytime, init write
// - jump width is field plus one quanta
// - prescaler divides by field plus one
// - init request aborts, drops sync, then acks
// - sleep taken only when bus idle
// - resync after eleven recessive bits
package cmc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CMC_OFS_CTL0 = 8'h00;
  localparam logic [7:0] CMC_OFS_CTL1 = 8'h04;
  localparam logic [7:0] CMC_OFS_BTR0 = 8'h08;
  localparam logic [7:0] CMC_OFS_STAT = 8'h0c;

  // control zero fields
  localparam int CMC_C0_INIT_REQ = 0;
  localparam int CMC_C0_SLEEP_REQ = 1;
  localparam int CMC_C0_WAKE_EN = 2;
  localparam int CMC_C0_RECOVER = 3;

  // control one fields
  localparam int CMC_C1_ENABLE = 7;
  localparam int CMC_C1_CLK_SEL = 6;
  localparam int CMC_C1_LOOPBACK = 5;
  localparam int CMC_C1_LISTEN = 4;
  localparam int CMC_C1_BUSOFF_SEL = 3;
  localparam int CMC_C1_WAKE_FILT = 2;
  localparam int CMC_C1_SLEEP_ACK = 1;
  localparam int CMC_C1_INIT_ACK = 0;

  // status fields
  localparam int CMC_ST_SYNCED = 0;
  localparam int CMC_ST_BUS_OFF = 1;
  localparam int CMC_ST_ENABLE_LOCK = 2;

  // reset values
  localparam logic [7:0] CMC_RST_CTL1 = 8'h00;
  localparam logic [7:0] CMC_RST_BTR0 = 8'h00;
  localparam logic CMC_RST_INIT_REQ = 1'b1;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CMC_CLK_NS = 20;
  localparam int CMC_WAKE_FILTER_NS = 2000;
  localparam int CMC_WAKE_CYC = (CMC_WAKE_FILTER_NS + CMC_CLK_NS - 1)
                                / CMC_CLK_NS;
  localparam logic [7:0] CMC_WAKE_CNT = 8'(CMC_WAKE_CYC);
  localparam logic [3:0] CMC_IDLE_BITS = 4'hb;

  typedef enum logic [1:0] {
    CMC_RUN   = 2'b00,
    CMC_ABORT = 2'b01,
    CMC_INIT  = 2'b10,
    CMC_SYNC  = 2'b11
  } cmc_mode_t;

endpackage

//--- inc/cmc_tq_if.sv
// Purpose: carries the time-quantum prescaler settings and tick
// Assumes: single clock domain
// Notes: ctrl side is the main module, gen side the divider
`timescale 1ns/1ps
`default_nettype none
interface cmc_tq_if;
  logic run;
  logic proto_en;
  logic [5:0] prescale;
  logic tq_tick;
  modport ctrl (output run, output proto_en, output prescale,
                input tq_tick);
  modport gen (input run, input proto_en, input prescale,
               output tq_tick);
endinterface
`default_nettype wire

//--- verilog/cmc_quantum_div.sv
// Purpose: divides the protocol clock enable into time-quantum ticks
// Assumes: proto_en is a one-cycle enable on clk_sys
// Notes: counter restarts whenever run is low
`timescale 1ns/1ps
`default_nettype none
module cmc_quantum_div (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // divider link
  cmc_tq_if.gen tq
);
  import cmc_pkg::*;

  logic [5:0] cnt_q;
  logic tick_q;

  // ----------------------------------------------------------------
  // divide by prescale plus one
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 6'h00;
      tick_q <= 1'b0;
    end else if (!tq.run) begin
      cnt_q <= 6'h00;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (tq.proto_en) begin
        if (cnt_q >= tq.prescale) begin
          cnt_q <= 6'h00;
          tick_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 6'h01;
        end
      end
    end
  end

  assign tq.tq_tick = tick_q;
endmodule
`default_nettype wire

//--- verilog/cmc_wake_filter.sv
// Purpose: wake-up detection on the synchronised receive level
// Assumes: rx_dom is already synchronised, 1 means dominant
// Notes: filtered mode needs an unbroken dominant pulse
`timescale 1ns/1ps
`default_nettype none
module cmc_wake_filter (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // control
  input wire logic armed,
  input wire logic filtered,
  input wire logic rx_dom,
  // result
  output logic wake
);
  import cmc_pkg::*;

  logic [7:0] cnt_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
    end else if (!armed || !rx_dom) begin
      cnt_q <= 8'h00;
    end else if (cnt_q != CMC_WAKE_CNT) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // glitches shorter than the filter time never wake the node; a pulse
  // of exactly the filter time wakes in its last cycle
  assign wake = armed && rx_dom &&
                (!filtered || cnt_q >= CMC_WAKE_CNT - 8'h01);
endmodule
`default_nettype wire

//--- dv/cmc_mode_ctrl_assertions.sv
// Purpose: port-level checks for the can mode control block
// Assumes: one clock, two-stage synchroniser on can_rx
// Notes: watches top ports only, attached by bind
`timescale 1ns/1ps
`default_nettype none
module cmc_mode_ctrl_chk (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  // pins and engine
  input wire logic can_rx,
  input wire logic can_tx,
  input wire logic tx_bit,
  input wire logic bus_off,
  input wire logic engine_run,
  input wire logic rx_bit,
  input wire logic abort,
  input wire logic bus_synced,
  input wire logic [2:0] jump_width,
  input wire logic suppress_ack_err,
  input wire logic err_cnt_freeze,
  input wire logic tx_start_ok,
  input wire logic recover_req
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  chk_listen_pair: assert property (
    suppress_ack_err |=> can_tx)
    else $error("pin driven in listen-only mode");
  // receiver sees either the own stream or the synchronised pin
  chk_rx_path: assert property (
    rx_bit == tx_bit || rx_bit == $past(can_rx, 2))
    else $error("receiver input from nowhere");
  chk_idle_tx: assert property (
    !engine_run |=> can_tx)
    else $error("pin driven while not running");
  chk_tx_gate: assert property (
    tx_start_ok |-> engine_run && !err_cnt_freeze)
    else $error("transmit allowed in listen or idle");
  chk_jump_range: assert property (
    jump_width inside {[3'd1:3'd4]})
    else $error("jump width out of range");
  chk_abort_pulse: assert property (
    abort |-> !engine_run ##1 !abort)
    else $error("abort not a single idle cycle");
  chk_recover_cause: assert property (
    recover_req |-> $past(psel && penable && pwrite && pwdata[3]
                          && bus_off && paddr == 8'h00))
    else $error("recovery pulse without request");
  chk_run_synced: assert property (
    engine_run |-> bus_synced)
    else $error("running before bus sync");
  // jump width may only move after a bus write to bit timing zero
  chk_timing_hold: assert property (
    !(psel && penable && pwrite && paddr == 8'h08) |=> $stable(jump_width))
    else $error("jump width changed without a write");
endmodule
bind cmc_mode_ctrl cmc_mode_ctrl_chk i_chk (
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .can_rx(can_rx),
  .can_tx(can_tx),
  .tx_bit(tx_bit),
  .bus_off(bus_off),
  .engine_run(engine_run),
  .rx_bit(rx_bit),
  .abort(abort),
  .bus_synced(bus_synced),
  .jump_width(jump_width),
  .suppress_ack_err(suppress_ack_err),
  .err_cnt_freeze(err_cnt_freeze),
  .tx_start_ok(tx_start_ok),
  .recover_req(recover_req)
);
`default_nettype wire

//--- dv/cmc_bus_node.sv
// Purpose: other node on the can bus, able to hold it dominant
// Assumes: wired-and bus, recessive is 1
// Notes: a pulse length is given in clk_sys cycles
`timescale 1ns/1ps
`default_nettype none
module cmc_bus_node (
  // clock
  input wire logic clk_sys,
  // bus
  input wire logic can_tx,
  output logic can_rx
);
  logic drive_q = 1'b1;
  // any dominant node wins, so the own pin shows up as well
  assign can_rx = drive_q & can_tx;
  task automatic dominant(input int n);
    @(posedge clk_sys);
    drive_q <= 1'b0;
    repeat (n) @(posedge clk_sys);
    drive_q <= 1'b1;
  endtask
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Purpose: register-level tests of the can mode control block
// Assumes: zero-wait apb slave, reset leaves init mode active
// Notes: engine side is stubbed by simple drivers here
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cmc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic special_mode = 1'b0;
  logic osc_en = 1'b0;
  logic tx_bit = 1'b1;
  logic sample_tick = 1'b0;
  logic rx_busy = 1'b0;
  logic tx_empty = 1'b1;
  logic bus_off = 1'b0;
  logic [31:0] prdata, rd_q;
  logic pready, pslverr, err_q, can_rx, can_tx, engine_run, rx_bit;
  logic abort, bus_synced, tq_tick, suppress_ack_err, err_cnt_freeze;
  logic tx_start_ok, auto_recover, recover_req;
  logic [2:0] jump_width;
  logic [1:0] st_q = 2'd0;
  int bad_count = 0;
  int samples_checked = 0;
  int tq_n = 0;
  int ab_n = 0;
  int rec_n = 0;
  int n0;
  cmc_mode_ctrl i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .can_rx(can_rx), .can_tx(can_tx), .special_mode(special_mode),
    .osc_en(osc_en), .tx_bit(tx_bit), .sample_tick(sample_tick),
    .rx_busy(rx_busy), .tx_empty(tx_empty), .bus_off(bus_off),
    .engine_run(engine_run), .rx_bit(rx_bit), .abort(abort),
    .bus_synced(bus_synced), .tq_tick(tq_tick), .jump_width(jump_width),
    .suppress_ack_err(suppress_ack_err), .err_cnt_freeze(err_cnt_freeze),
    .tx_start_ok(tx_start_ok), .auto_recover(auto_recover),
    .recover_req(recover_req));
  cmc_bus_node i_bus (.clk_sys(clk_sys), .can_tx(can_tx), .can_rx(can_rx));
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  // oscillator enable at half rate, sample point every fourth cycle
  always @(posedge clk_sys) begin
    osc_en <= ~osc_en;
    st_q <= st_q + 2'd1;
    sample_tick <= (st_q == 2'd0);
    if (tq_tick === 1'b1) tq_n <= tq_n + 1;
    if (abort === 1'b1) ab_n <= ab_n + 1;
    if (recover_req === 1'b1) rec_n <= rec_n + 1;
  end
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // no limit here: the watchdog ends a bus that never answers
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic sig_chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t signal %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    samples_checked++;
    if (rd_q !== exp) begin
      bad_count++;
      $display("ERROR %0t read %h at %h expected %h", $time, rd_q, a, exp);
    end
  endtask
  task automatic tick_chk(input int cyc, input int exp);
    repeat (8) @(posedge clk_sys);
    n0 = tq_n;
    repeat (cyc) @(posedge clk_sys);
    sig_chk(8'(tq_n - n0), 8'(exp));
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    $display("ERROR %0t watchdog expired", $time);
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reg_chk(CMC_OFS_CTL1, 32'h01);
    reg_chk(CMC_OFS_BTR0, 32'h00);
    reg_chk(8'h10, 32'h00);
    sig_chk(8'(err_q), 8'h01);
    $display("test reset done");
    apb(1'b1, CMC_OFS_BTR0, 32'hc3);
    reg_chk(CMC_OFS_BTR0, 32'hc3);
    sig_chk(8'(jump_width), 8'h04);
    apb(1'b1, CMC_OFS_CTL1, 32'hc0);
    reg_chk(CMC_OFS_CTL1, 32'hc1);
    tick_chk(80, 20);
    // normal mode: the enable bit stays set once written
    apb(1'b1, CMC_OFS_CTL1, 32'h1c);
    reg_chk(CMC_OFS_CTL1, 32'h9d);
    tick_chk(80, 10);
    sig_chk(8'(err_cnt_freeze), 8'h01);
    sig_chk(8'(suppress_ack_err), 8'h01);
    sig_chk(8'(auto_recover), 8'h00);
    $display("test config done");
    special_mode <= 1'b1;
    repeat (3) @(posedge clk_sys);
    apb(1'b1, CMC_OFS_CTL1, 32'h1c);
    reg_chk(CMC_OFS_CTL1, 32'h1d);
    tick_chk(80, 0);
    apb(1'b1, CMC_OFS_CTL1, 32'hbc);
    tx_bit <= 1'b0;
    repeat (2) @(posedge clk_sys);
    sig_chk(8'(rx_bit), 8'h00);
    tx_bit <= 1'b1;
    apb(1'b1, CMC_OFS_CTL1, 32'h9c);
    special_mode <= 1'b0;
    $display("test special done");
    apb(1'b1, CMC_OFS_CTL0, 32'h04);
    n0 = 0;
    while (bus_synced !== 1'b1 && n0 < 300) begin
      @(posedge clk_sys);
      n0++;
    end
    sig_chk(8'(bus_synced), 8'h01);
    reg_chk(CMC_OFS_CTL1, 32'h9c);
    sig_chk(8'(tx_start_ok), 8'h00);
    sig_chk(8'(engine_run), 8'h01);
    reg_chk(CMC_OFS_STAT, 32'h05);
    apb(1'b1, CMC_OFS_CTL1, 32'h00);
    reg_chk(CMC_OFS_CTL1, 32'h9c);
    apb(1'b1, CMC_OFS_BTR0, 32'h00);
    reg_chk(CMC_OFS_BTR0, 32'hc3);
    bus_off <= 1'b1;
    apb(1'b1, CMC_OFS_CTL0, 32'h0c);
    repeat (3) @(posedge clk_sys);
    sig_chk(8'(rec_n), 8'h01);
    bus_off <= 1'b0;
    $display("test run done");
    rx_busy <= 1'b1;
    tx_empty <= 1'b0;
    apb(1'b1, CMC_OFS_CTL0, 32'h06);
    repeat (10) @(posedge clk_sys);
    reg_chk(CMC_OFS_CTL1, 32'h9c);
    rx_busy <= 1'b0;
    repeat (3) @(posedge clk_sys);
    reg_chk(CMC_OFS_CTL1, 32'h9c);
    tx_empty <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reg_chk(CMC_OFS_CTL1, 32'h9e);
    // a glitch shorter than the filter time must not wake
    i_bus.dominant(50);
    repeat (5) @(posedge clk_sys);
    reg_chk(CMC_OFS_CTL1, 32'h9e);
    i_bus.dominant(120);
    repeat (5) @(posedge clk_sys);
    reg_chk(CMC_OFS_CTL1, 32'h9c);
    reg_chk(CMC_OFS_CTL0, 32'h04);
    apb(1'b1, CMC_OFS_CTL0, 32'h06);
    repeat (3) @(posedge clk_sys);
    reg_chk(CMC_OFS_CTL1, 32'h9e);
    apb(1'b1, CMC_OFS_CTL0, 32'h04);
    reg_chk(CMC_OFS_CTL1, 32'h9c);
    $display("test sleep done");
    n0 = ab_n;
    apb(1'b1, CMC_OFS_CTL0, 32'h05);
    repeat (3) @(posedge clk_sys);
    sig_chk(8'(ab_n - n0), 8'h01);
    reg_chk(CMC_OFS_CTL1, 32'h9d);
    sig_chk(8'(bus_synced), 8'h00);
    sig_chk(8'(can_tx), 8'h01);
    sig_chk(8'(engine_run), 8'h00);
    $display("test init done");
    print_verdict();
  end
endmodule
`default_nettype wire
